/* hdl/sbgpa_pkg.sv */
// Purpose: Shared constants and types for the six-bit general purpose port.
// Assumes: Eight-bit register bus with eight address bits.
// Notes: Offsets of the register map are fixed here and used by the port logic.
package sbgpa_pkg;

  // Width of the register bus address and data.
  localparam int SBGPA_AW = 8;
  localparam int SBGPA_DW = 8;
  // Number of implemented port pins.
  localparam int SBGPA_PINS = 6;

  // Register offsets.
  localparam logic [7:0] SBGPA_OFS_VALUE = 8'h00;
  localparam logic [7:0] SBGPA_OFS_LATCH = 8'h01;
  localparam logic [7:0] SBGPA_OFS_DIR = 8'h02;
  localparam logic [7:0] SBGPA_OFS_ANALOG = 8'h03;
  localparam logic [7:0] SBGPA_OFS_INLVL = 8'h04;
  localparam logic [7:0] SBGPA_OFS_ALTSEL = 8'h05;

  // Implemented bit masks of each register.
  localparam logic [7:0] SBGPA_MASK_PINS = 8'h3f;
  localparam logic [7:0] SBGPA_MASK_LATCH = 8'h37;
  localparam logic [7:0] SBGPA_MASK_ANALOG = 8'h17;
  localparam logic [7:0] SBGPA_MASK_ALTSEL = 8'h07;

  // Reset values.
  localparam logic [7:0] SBGPA_RST_DIR = 8'h3f;
  localparam logic [7:0] SBGPA_RST_ANALOG = 8'h17;
  localparam logic [7:0] SBGPA_RST_INLVL = 8'h00;
  localparam logic [7:0] SBGPA_RST_LATCH = 8'h00;
  localparam logic [7:0] SBGPA_RST_ALTSEL = 8'h00;

  // Position of the input-only pin.
  localparam int SBGPA_PIN_IN_ONLY = 3;

  // Alternate select field positions.
  localparam int SBGPA_ALT_PWM_B = 0;
  localparam int SBGPA_ALT_CAPTURE_COMPARE_TWO_OUT = 1;
  localparam int SBGPA_ALT_RXDT = 2;

  // One bit per peripheral output function; used for enables and for data.
  typedef struct packed {
    logic serial_program_data;
    logic debug_data_line;
    logic dac_output_pin;
    logic serial_program_clock;
    logic debug_clock_line;
    logic serial_receive_or_data;
    logic sr_latch_output;
    logic comparator_one_output;
    logic capture_compare_three_out;
    logic instruction_clock_output;
    logic timer_one_osc_output;
    logic reference_clock_output;
    logic serial_out_port_one;
    logic pwm_two_channel_b;
    logic serial_out_port_two;
    logic capture_compare_two_out;
  } sbgpa_periph_t;

  // Pin side signals of all six pads.
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe_n;
  } sbgpa_pad_drive_t;

endpackage

/* hdl/sbgpa_port.sv */
// Purpose: Six-bit general purpose port (pin 3 input only, others bidirectional) with latch, direction,
//   analog select, input threshold select and peripheral output priority.
// Assumes: Single clock; pads give one Schmitt and one TTL digital sample each.
// Notes: Pad inputs pass two flip-flops before any logic reads them.
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module sbgpa_port
  import sbgpa_pkg::*;
#(
  parameter int PINS = sbgpa_pkg::SBGPA_PINS
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [sbgpa_pkg::SBGPA_AW-1:0] reg_addr,
  input wire logic [sbgpa_pkg::SBGPA_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [sbgpa_pkg::SBGPA_DW-1:0] reg_rdata,
  input wire logic [5:0] pad_in_schmitt,
  input wire logic [5:0] pad_in_ttl,
  output logic [5:0] pad_out,
  output logic [5:0] pad_oe_n,
  input wire sbgpa_pkg::sbgpa_periph_t periph_en,
  input wire sbgpa_pkg::sbgpa_periph_t periph_dat,
  output logic [5:0] digital_in,
  output logic [5:0] analog_active
);
  import sbgpa_pkg::*;

  // Two-stage synchronisers for both threshold samples of every pad.
  logic [5:0] st_meta_reg;
  logic [5:0] st_sync_reg;
  logic [5:0] ttl_meta_reg;
  logic [5:0] ttl_sync_reg;

  // Software visible registers.
  logic [7:0] latch_reg;
  logic [7:0] latch_next;
  logic [7:0] dir_reg;
  logic [7:0] dir_next;
  logic [7:0] analog_reg;
  logic [7:0] analog_next;
  logic [7:0] inlvl_reg;
  logic [7:0] inlvl_next;
  logic [7:0] altsel_reg;
  logic [7:0] altsel_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Registered pad drive and the next values computed for it.
  sbgpa_pad_drive_t drive_reg;
  sbgpa_pad_drive_t drive_next;
  logic [5:0] din_reg;

  // Address decode strobes.
  wire logic sel_value = (reg_addr == SBGPA_OFS_VALUE);
  wire logic sel_latch = (reg_addr == SBGPA_OFS_LATCH);
  wire logic sel_dir = (reg_addr == SBGPA_OFS_DIR);
  wire logic sel_analog = (reg_addr == SBGPA_OFS_ANALOG);
  wire logic sel_inlvl = (reg_addr == SBGPA_OFS_INLVL);
  wire logic sel_altsel = (reg_addr == SBGPA_OFS_ALTSEL);

  // Threshold choice and analog gating of the digital read path.
  wire logic [5:0] thresh_level;
  wire logic [5:0] pin_read;
  wire logic [7:0] value_read;

  // Per-pin selected function data and whether any function owns the pin.
  logic [5:0] fn_own;
  logic [5:0] fn_dat;

  // Alternate routing of relocatable functions.
  wire logic pwm_b_here = altsel_reg[SBGPA_ALT_PWM_B];
  wire logic capture_compare_two_out_here = altsel_reg[SBGPA_ALT_CAPTURE_COMPARE_TWO_OUT];
  wire logic rxdt_here = ~altsel_reg[SBGPA_ALT_RXDT];

  // Synchronise the pad samples before anything else looks at them.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_meta_reg <= 6'h00;
      st_sync_reg <= 6'h00;
      ttl_meta_reg <= 6'h00;
      ttl_sync_reg <= 6'h00;
    end
    else
    begin
      st_meta_reg <= pad_in_schmitt;
      st_sync_reg <= st_meta_reg;
      ttl_meta_reg <= pad_in_ttl;
      ttl_sync_reg <= ttl_meta_reg;
    end
  end

  // Per-pin read path, one generate entry per pin.
  // six pins, bits 0..5
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++)
    begin : g_read
      assign thresh_level[gi] = inlvl_reg[gi] ? st_sync_reg[gi] : ttl_sync_reg[gi];
      assign pin_read[gi] = thresh_level[gi] & ~analog_reg[gi];
    end
  endgenerate

  assign value_read = {2'b00, pin_read};

  // Output priority per pin; the first enabled entry in each list wins.
  always_comb
  begin
    fn_own = 6'h00;
    fn_dat = 6'h00;
    if (periph_en.serial_program_data)
    begin
      fn_own[0] = 1'b1;
      fn_dat[0] = periph_dat.serial_program_data;
    end
    else if (periph_en.debug_data_line)
    begin
      fn_own[0] = 1'b1;
      fn_dat[0] = periph_dat.debug_data_line;
    end
    else if (periph_en.dac_output_pin)
    begin
      fn_own[0] = 1'b1;
      fn_dat[0] = periph_dat.dac_output_pin;
    end
    if (periph_en.serial_program_clock)
    begin
      fn_own[1] = 1'b1;
      fn_dat[1] = periph_dat.serial_program_clock;
    end
    else if (periph_en.debug_clock_line)
    begin
      fn_own[1] = 1'b1;
      fn_dat[1] = periph_dat.debug_clock_line;
    end
    else if (periph_en.serial_receive_or_data && rxdt_here)
    begin
      fn_own[1] = 1'b1;
      fn_dat[1] = periph_dat.serial_receive_or_data;
    end
    if (periph_en.sr_latch_output)
    begin
      fn_own[2] = 1'b1;
      fn_dat[2] = periph_dat.sr_latch_output;
    end
    else if (periph_en.comparator_one_output)
    begin
      fn_own[2] = 1'b1;
      fn_dat[2] = periph_dat.comparator_one_output;
    end
    else if (periph_en.capture_compare_three_out)
    begin
      fn_own[2] = 1'b1;
      fn_dat[2] = periph_dat.capture_compare_three_out;
    end
    if (periph_en.instruction_clock_output)
    begin
      fn_own[4] = 1'b1;
      fn_dat[4] = periph_dat.instruction_clock_output;
    end
    else if (periph_en.timer_one_osc_output)
    begin
      fn_own[4] = 1'b1;
      fn_dat[4] = periph_dat.timer_one_osc_output;
    end
    else if (periph_en.reference_clock_output)
    begin
      fn_own[4] = 1'b1;
      fn_dat[4] = periph_dat.reference_clock_output;
    end
    else if (periph_en.serial_out_port_one)
    begin
      fn_own[4] = 1'b1;
      fn_dat[4] = periph_dat.serial_out_port_one;
    end
    else if (periph_en.pwm_two_channel_b && pwm_b_here)
    begin
      fn_own[4] = 1'b1;
      fn_dat[4] = periph_dat.pwm_two_channel_b;
    end
    if (periph_en.serial_out_port_two)
    begin
      fn_own[5] = 1'b1;
      fn_dat[5] = periph_dat.serial_out_port_two;
    end
    else if (periph_en.capture_compare_two_out && capture_compare_two_out_here)
    begin
      fn_own[5] = 1'b1;
      fn_dat[5] = periph_dat.capture_compare_two_out;
    end
  end

  // Pad drive: data from the owning function or the latch, driver from
  // the direction bit alone, so analog select plays no part here.
  always_comb
  begin
    drive_next.out = 6'h00;
    drive_next.oe_n = 6'h3f;
    for (int i = 0; i < PINS; i++)
    begin
      drive_next.out[i] = fn_own[i] ? fn_dat[i] : latch_reg[i];
      drive_next.oe_n[i] = dir_reg[i];
    end
    drive_next.out[SBGPA_PIN_IN_ONLY] = 1'b0;
    drive_next.oe_n[SBGPA_PIN_IN_ONLY] = 1'b1;
  end

  // Register write decode; only implemented bits ever change.
  always_comb
  begin
    latch_next = latch_reg;
    dir_next = dir_reg;
    analog_next = analog_reg;
    inlvl_next = inlvl_reg;
    altsel_next = altsel_reg;
    if (reg_wr)
    begin
      if (sel_value || sel_latch)
      begin
        latch_next = reg_wdata & SBGPA_MASK_LATCH;
      end
      if (sel_dir)
      begin
        dir_next = (reg_wdata & SBGPA_MASK_PINS) | (8'h01 << SBGPA_PIN_IN_ONLY);
      end
      if (sel_analog)
      begin
        analog_next = reg_wdata & SBGPA_MASK_ANALOG;
      end
      if (sel_inlvl)
      begin
        inlvl_next = reg_wdata & SBGPA_MASK_PINS;
      end
      if (sel_altsel)
      begin
        altsel_next = reg_wdata & SBGPA_MASK_ALTSEL;
      end
    end
  end

  // Read mux; an unmapped address or an idle cycle returns zero, so the
  // read data stand only in the cycle after a read strobe.
  // port read returns pins
  assign rdata_next = !reg_rd ? 8'h00 :
    sel_value ? value_read :
    sel_latch ? latch_reg :
    sel_dir ? dir_reg :
    sel_analog ? analog_reg :
    sel_inlvl ? inlvl_reg :
    sel_altsel ? altsel_reg :
    8'h00;

  // Register state; direction resets to all inputs.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      latch_reg <= SBGPA_RST_LATCH;
      dir_reg <= SBGPA_RST_DIR;
      analog_reg <= SBGPA_RST_ANALOG;
      inlvl_reg <= SBGPA_RST_INLVL;
      altsel_reg <= SBGPA_RST_ALTSEL;
      rdata_reg <= 8'h00;
      drive_reg <= '{out: 6'h00, oe_n: 6'h3f};
      din_reg <= 6'h00;
    end
    else
    begin
      latch_reg <= latch_next;
      dir_reg <= dir_next;
      analog_reg <= analog_next;
      inlvl_reg <= inlvl_next;
      altsel_reg <= altsel_next;
      rdata_reg <= rdata_next;
      drive_reg <= drive_next;
      din_reg <= pin_read;
    end
  end

  // Outputs come straight from flip-flops.
  assign reg_rdata = rdata_reg;
  assign pad_out = drive_reg.out;
  assign pad_oe_n = drive_reg.oe_n;
  assign digital_in = din_reg;
  assign analog_active = analog_reg[5:0];

endmodule

/* verification/sbgpa_pad_model.sv */
// Purpose: Pins and their outside world for the port.
// Assumes: A driven pin shows the port's data, a released one the outside level.
// Notes: split marks pins whose level falls between the two thresholds.
`timescale 1ns/100ps
module sbgpa_pad_model (
  input wire logic [5:0] pad_out,
  input wire logic [5:0] pad_oe_n,
  input wire logic [5:0] ext_lvl,
  input wire logic [5:0] split,
  output logic [5:0] pad_in_schmitt,
  output logic [5:0] pad_in_ttl
);
  // Resolved wire level from both drivers.
  wire [5:0] pin_lvl = (pad_out & ~pad_oe_n) | (ext_lvl & pad_oe_n);
  assign pad_in_ttl = pin_lvl;
  assign pad_in_schmitt = pin_lvl ^ split;
endmodule

/* verification/sbgpa_port_monitor.sv */
// Purpose: Timing checks on the port's register bus and pads.
// Assumes: Ports as declared by sbgpa_port.
// Notes: Tracks the last direction write to check the drivers.
`timescale 1ns/100ps
module sbgpa_port_monitor
  import sbgpa_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [5:0] pad_out,
  input wire logic [5:0] pad_oe_n,
  input wire logic [5:0] digital_in,
  input wire logic [5:0] analog_active
);
  // Last value written to the direction register.
  logic [7:0] dir_wd_reg;
  wire dir_wr = reg_wr && (reg_addr == SBGPA_OFS_DIR);
  wire val_rd = reg_rd && (reg_addr == SBGPA_OFS_VALUE);
  wire dir_rd = reg_rd && (reg_addr == SBGPA_OFS_DIR);
  // Captures direction data as it is written.
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst) dir_wd_reg <= 8'h3f;
    else if (dir_wr) dir_wd_reg <= reg_wdata;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_pin_three_off: assert property (pad_oe_n[3] && !pad_out[3])
    else $error("pin three driven");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read");
  a_rdata_upper: assert property (reg_rd |=> reg_rdata[7:6] == 2'h0)
    else $error("upper read bits set");
  a_dir_bit_three: assert property (dir_rd |=> reg_rdata[3])
    else $error("direction bit three low");
  a_analog_gate: assert property (val_rd ##1 $stable(analog_active) |->
    (reg_rdata[5:0] & analog_active) == 6'h00)
    else $error("analog pin read as one");
  a_dir_driver: assert property (dir_wr ##1 !dir_wr |=>
    pad_oe_n == (dir_wd_reg[5:0] | 6'h08))
    else $error("driver enable mismatch");
  a_reset_analog: assert property ($rose(nrst) |-> analog_active == 6'h17)
    else $error("analog select not reset");
  a_digital_gate: assert property ($stable(analog_active) [*4] |->
    (digital_in & analog_active) == 6'h00)
    else $error("analog pin seen as one");
endmodule

/* verification/tb_top.sv */
// Purpose: Self-checking bench for the six-bit port.
// Assumes: Seeded random register setups with fixed corner cases.
// Notes: Expectations come from local tables, the local function exp_out and inline expressions only.
`timescale 1ns/100ps
module tb_top;
  import sbgpa_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [5:0] ext_lvl = 6'h00;
  logic [5:0] split = 6'h00;
  sbgpa_periph_t periph_en = '0;
  sbgpa_periph_t periph_dat = '0;
  wire [7:0] reg_rdata;
  wire [5:0] pad_out, pad_oe_n, digital_in, analog_active, sch, ttl;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] rv, dir, lat, ana, inl, alt;
  logic [5:0] eo, lvl, val;
  sbgpa_periph_t en, dat;
  // Register offsets with reset values and writable masks; 8'h07 is unmapped.
  logic [7:0] ofs [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07};
  logic [7:0] rst [6] = '{8'h00, 8'h3f, 8'h17, 8'h00, 8'h00, 8'h00};
  logic [7:0] msk [6] = '{8'h37, 8'h3f, 8'h17, 8'h3f, 8'h07, 8'h00};
  always #50 sys_clk = ~sys_clk;
  sbgpa_port u_sbgpa_port (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pad_in_schmitt(sch), .pad_in_ttl(ttl), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .periph_en(periph_en), .periph_dat(periph_dat), .digital_in(digital_in),
    .analog_active(analog_active));
  sbgpa_pad_model u_sbgpa_pad_model (.pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .ext_lvl(ext_lvl), .split(split), .pad_in_schmitt(sch), .pad_in_ttl(ttl));
  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Verdict and end of run.
  task automatic complete_run;
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Counts a comparison and reports a mismatch.
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One-cycle read strobe; data taken in the following cycle.
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 cmp(nm, e, reg_rdata);
  endtask
  // Pin data after priority; later lines outrank earlier ones.
  function automatic logic [5:0] exp_out(sbgpa_periph_t e, sbgpa_periph_t d,
    logic [7:0] l, logic [7:0] a);
    logic [5:0] o;
    o = l[5:0];
    if (e.dac_output_pin) o[0] = d.dac_output_pin;
    if (e.debug_data_line) o[0] = d.debug_data_line;
    if (e.serial_program_data) o[0] = d.serial_program_data;
    if (e.serial_receive_or_data && !a[2]) o[1] = d.serial_receive_or_data;
    if (e.debug_clock_line) o[1] = d.debug_clock_line;
    if (e.serial_program_clock) o[1] = d.serial_program_clock;
    if (e.capture_compare_three_out) o[2] = d.capture_compare_three_out;
    if (e.comparator_one_output) o[2] = d.comparator_one_output;
    if (e.sr_latch_output) o[2] = d.sr_latch_output;
    if (e.pwm_two_channel_b && a[0]) o[4] = d.pwm_two_channel_b;
    if (e.serial_out_port_one) o[4] = d.serial_out_port_one;
    if (e.reference_clock_output) o[4] = d.reference_clock_output;
    if (e.timer_one_osc_output) o[4] = d.timer_one_osc_output;
    if (e.instruction_clock_output) o[4] = d.instruction_clock_output;
    if (e.capture_compare_two_out && a[1]) o[5] = d.capture_compare_two_out;
    if (e.serial_out_port_two) o[5] = d.serial_out_port_two;
    return o;
  endfunction
  // Hang guard.
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 10000)
    begin
      n_errors++;
      complete_run();
    end
  end
  // Reset values, masks, then random setups.
  initial
  begin
    rv = $urandom(35);
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) chk_rd("reset", ofs[i], rst[i]);
    for (int i = 0; i < 6; i++)
    begin
      wr(ofs[i], 8'hff);
      chk_rd("mask", ofs[i], msk[i]);
    end
    wr(SBGPA_OFS_VALUE, 8'h2a);
    chk_rd("latch", SBGPA_OFS_LATCH, 8'h22);
    for (int k = 0; k < 40; k++)
    begin
      dir = 8'($urandom);
      lat = $urandom & 8'h37;
      ana = $urandom & 8'h17;
      inl = $urandom & 8'h3f;
      alt = $urandom & 8'h07;
      en = 16'($urandom);
      dat = 16'($urandom);
      // analog pins kept as inputs in half the setups
      if (k[1]) dir = dir | ana;
      wr(SBGPA_OFS_DIR, dir);
      periph_en <= '0;
      // Bit three always reads one and bits 7..6 are dropped.
      dir = (dir & 8'h3f) | 8'h08;
      wr(k[0] ? SBGPA_OFS_VALUE : SBGPA_OFS_LATCH, lat);
      wr(SBGPA_OFS_ANALOG, ana);
      wr(SBGPA_OFS_INLVL, inl);
      wr(SBGPA_OFS_ALTSEL, alt);
      periph_en <= en;
      periph_dat <= dat;
      ext_lvl <= 6'($urandom);
      split <= 6'($urandom);
      repeat (5) @(posedge sys_clk);
      #1 eo = exp_out(en, dat, lat, alt);
      lvl = (eo & ~dir[5:0]) | (ext_lvl & dir[5:0]);
      val = ((inl[5:0] & (lvl ^ split)) | (~inl[5:0] & lvl)) & ~ana[5:0];
      cmp("oe", dir & 8'h3f, {2'h0, pad_oe_n});
      cmp("out", {2'h0, eo | dir[5:0]}, {2'h0, pad_out | dir[5:0]});
      cmp("din", {2'h0, val}, {2'h0, digital_in});
      cmp("ana", ana, {2'h0, analog_active});
      chk_rd("value", SBGPA_OFS_VALUE, {2'h0, val});
      chk_rd("dir", SBGPA_OFS_DIR, dir);
    end
    // Mid-run reset: analog select and direction return to reset values.
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    chk_rd("reset ana", SBGPA_OFS_ANALOG, 8'h17);
    chk_rd("reset dir", SBGPA_OFS_DIR, 8'h3f);
    complete_run();
  end
endmodule
bind sbgpa_port sbgpa_port_monitor u_sbgpa_port_monitor (.sys_clk(sys_clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
  .digital_in(digital_in), .analog_active(analog_active));
